// ==== src/smbra_pkg.sv ====
`default_nettype none
package smbra_pkg;

   // Fixed-address mode: strap level picks one of four addresses
   localparam logic [6:0] FIXED_ADDR_BASE   = 7'h50;
   localparam int         STRAP_W           = 2;

   // Register file
   localparam int         NUM_REGS          = 32;
   localparam int         REG_IDX_W         = 5;
   localparam logic [4:0] REG_BLOCK_READ_LEN = 5'h00;
   localparam logic [7:0] RST_BLOCK_READ_LEN = 8'h01;
   localparam logic [7:0] RST_REG_VALUE      = 8'h00;
   localparam logic [7:0] RST_POINTER        = 8'h00;
   localparam logic [7:0] UNMAPPED_READ      = 8'h00;
   localparam logic [7:0] PAST_BLOCK_READ    = 8'hff;

   // Pointer fields
   localparam int         PTR_BLOCK_BIT     = 7;
   localparam int         PTR_HI_MSB        = 6;
   localparam int         PTR_HI_LSB        = 5;

   // Byte framing on the link
   localparam logic [3:0] BIT_FIRST         = 4'h1;
   localparam logic [3:0] BIT_LAST          = 4'h7;
   localparam logic [3:0] ACK_SLOT          = 4'h8;
   localparam logic [5:0] MAX_BLOCK         = 6'd32;

   typedef enum logic [2:0] {
      SMBRA_IDLE   = 3'b000,
      SMBRA_ADDR   = 3'b001,
      SMBRA_PTR    = 3'b011,
      SMBRA_COUNT  = 3'b010,
      SMBRA_DATA_W = 3'b110,
      SMBRA_READ   = 3'b111
   } smbra_state_t;

   // Context of the transfer in progress
   typedef struct packed {
      logic       block;
      logic [5:0] left;
   } smbra_xfer_t;

endpackage
`default_nettype wire

// ==== src/smbra_slave.sv ====
// Summary of operation
// - Detect start, then shift in eight bits
// - First byte is address plus direction bit
// - Matching address: pull SDA low for ack
// - Non-matching address: stay idle, SDA released
// - Direction 0 writes, direction 1 reads
// - Each byte is eight bits plus ack
// - SDA rise while SCL high is stop
// - Direction changes only after new start
// - First written byte loads register pointer
// - Second written byte stores to pointed register
// - Read returns pointed register without rewrite
// - Own address latched from strap after reset
// - Pointer top bit selects single or block
// - Block read length from register zero
// - Send byte acks both, updates pointer only
// - Repeated start then read returns selected register
// - Top bit set on write means block
// - Block write: count then data, bytes past the count not acked
// - Block write carries at most 32 bytes
// - Block read sends count then that many
// - Strap picks fixed address 0x50 to 0x53
`timescale 1ns/10ps
`default_nettype none
module smbra_slave (
   input  wire logic                         CORE_CLK,
   input  wire logic                         RSTN,
   input  wire logic                         SCL,
   input  wire logic                         SDA_IN,
   output var  logic                         SDA_OUT,
   output var  logic                         SDA_OE_N,
   input  wire logic [smbra_pkg::STRAP_W-1:0] ADDRESS_STRAP_PIN,
   output var  logic [6:0]                   SLAVE_ADDR,
   output var  logic                         BUSY
);

   function automatic logic [5:0] clamp_count(input logic [7:0] b);
      if (b > {2'b00, smbra_pkg::MAX_BLOCK}) begin
         return smbra_pkg::MAX_BLOCK;
      end
      return b[5:0];
   endfunction

   function automatic logic tx_bit(input logic [7:0] b, input logic [3:0] n);
      logic [3:0] k;
      k = smbra_pkg::BIT_LAST - n;
      return b[k[2:0]];
   endfunction

   // Core clock domain
   logic [smbra_pkg::STRAP_W-1:0] strap_meta;
   logic [smbra_pkg::STRAP_W-1:0] strap_sync;
   logic                          strap_taken;
   logic                          busy_meta;
   // Link domain (SCL, except start/stop toggles clocked by SDA edges)
   logic                          rst_meta;
   logic                          link_rstn;
   logic [6:0]                    addr_meta;
   logic [6:0]                    addr_link;
   logic                          start_tgl;
   logic                          stop_tgl;
   logic                          start_ack;
   logic                          stop_ack;
   smbra_pkg::smbra_state_t       state;
   logic [3:0]                    bitcnt;
   logic [7:0]                    shreg;
   logic [7:0]                    ptr;
   logic [7:0]                    tx;
   logic                          ack_en;
   logic                          link_busy;
   smbra_pkg::smbra_xfer_t        xfer;
   logic [7:0]                    regs [smbra_pkg::NUM_REGS];
   // Combinational
   logic                          start_pend;
   logic                          stop_pend;
   logic [7:0]                    in_byte;
   logic                          byte_done;
   logic                          addr_hit;
   logic                          ptr_mapped;
   logic [7:0]                    cur_rd;
   logic [5:0]                    read_len;
   logic                          wr_en;

   // Strap capture, once after reset release
   always_ff @(posedge CORE_CLK) begin
      strap_meta <= ADDRESS_STRAP_PIN;
      strap_sync <= strap_meta;
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RSTN) begin
         strap_taken <= 1'b0;
         SLAVE_ADDR  <= smbra_pkg::FIXED_ADDR_BASE;
      end else if (!strap_taken) begin
         // Later strap changes are ignored, no reassignment possible
         strap_taken <= 1'b1;
         SLAVE_ADDR  <= smbra_pkg::FIXED_ADDR_BASE | {5'h00, strap_sync};
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RSTN) begin
         busy_meta <= 1'b0;
         BUSY      <= 1'b0;
      end else begin
         busy_meta <= link_busy;
         BUSY      <= busy_meta;
      end
   end

   // Reset and address brought into the link domain
   always_ff @(posedge SCL) begin
      rst_meta  <= RSTN;
      link_rstn <= rst_meta;
   end

   // Address is static after capture, so a level crossing is enough
   always_ff @(posedge SCL) begin
      addr_meta <= SLAVE_ADDR;
      addr_link <= addr_meta;
   end

   // Start and stop can only be seen on SDA edges while SCL is high
   always_ff @(negedge SDA_IN) begin
      if (!link_rstn) begin
         start_tgl <= 1'b0;
      end else if (SCL) begin
         start_tgl <= ~start_tgl;
      end
   end

   always_ff @(posedge SDA_IN) begin
      if (!link_rstn) begin
         stop_tgl <= 1'b0;
      end else if (SCL) begin
         stop_tgl <= ~stop_tgl;
      end
   end

   assign start_pend = start_tgl ^ start_ack;
   assign stop_pend  = stop_tgl ^ stop_ack;
   assign in_byte    = {shreg[6:0], SDA_IN};
   assign byte_done  = !start_pend && !stop_pend && (bitcnt == smbra_pkg::BIT_LAST)
                       && (state != smbra_pkg::SMBRA_IDLE) && (state != smbra_pkg::SMBRA_READ);
   assign addr_hit   = (in_byte[7:1] == addr_link);
   assign ptr_mapped = (ptr[smbra_pkg::PTR_HI_MSB:smbra_pkg::PTR_HI_LSB] == 2'b00);
   assign cur_rd     = ptr_mapped ? regs[ptr[smbra_pkg::REG_IDX_W-1:0]]
                                  : smbra_pkg::UNMAPPED_READ;
   assign read_len   = clamp_count(regs[smbra_pkg::REG_BLOCK_READ_LEN]);
   assign wr_en      = byte_done && (state == smbra_pkg::SMBRA_DATA_W) && ptr_mapped
                       && (!xfer.block || (xfer.left != 6'd0));

   // Byte framing and protocol state, sampled on rising SCL
   always_ff @(posedge SCL) begin
      if (!link_rstn) begin
         start_ack <= start_tgl;
         stop_ack  <= stop_tgl;
         state     <= smbra_pkg::SMBRA_IDLE;
         bitcnt    <= 4'h0;
         shreg     <= 8'h00;
         ptr       <= smbra_pkg::RST_POINTER;
         tx        <= 8'h00;
         ack_en    <= 1'b0;
         xfer      <= '0;
      end else begin
         start_ack <= start_tgl;
         stop_ack  <= stop_tgl;
         if (start_pend) begin
            // This edge already carries the first address bit
            state  <= smbra_pkg::SMBRA_ADDR;
            bitcnt <= smbra_pkg::BIT_FIRST;
            shreg  <= {7'h00, SDA_IN};
            ack_en <= 1'b0;
         end else if (stop_pend || state == smbra_pkg::SMBRA_IDLE) begin
            state  <= smbra_pkg::SMBRA_IDLE;
            bitcnt <= 4'h0;
            ack_en <= 1'b0;
         end else if (bitcnt == smbra_pkg::ACK_SLOT) begin
            bitcnt <= 4'h0;
            ack_en <= 1'b0;
            // Own ack of the read address: first byte already loaded,
            // reloading here would lose the block count and skip a register
            if (state == smbra_pkg::SMBRA_READ && !ack_en) begin
               if (SDA_IN) begin
                  state <= smbra_pkg::SMBRA_IDLE;
               end else if (!xfer.block) begin
                  tx <= cur_rd;
               end else if (xfer.left != 6'd0) begin
                  tx        <= cur_rd;
                  ptr       <= {ptr[7], ptr[6:0] + 7'h01};
                  xfer.left <= xfer.left - 6'd1;
               end else begin
                  tx <= smbra_pkg::PAST_BLOCK_READ;
               end
            end
         end else begin
            bitcnt <= bitcnt + 4'h1;
            shreg  <= in_byte;
            if (byte_done) begin
               ack_en <= 1'b1;
               case (state)
                  smbra_pkg::SMBRA_ADDR: begin
                     if (!addr_hit) begin
                        state  <= smbra_pkg::SMBRA_IDLE;
                        ack_en <= 1'b0;
                     end else if (in_byte[0]) begin
                        state      <= smbra_pkg::SMBRA_READ;
                        xfer.block <= ptr[smbra_pkg::PTR_BLOCK_BIT];
                        xfer.left  <= read_len;
                        tx         <= ptr[smbra_pkg::PTR_BLOCK_BIT] ? {2'b00, read_len}
                                                                    : cur_rd;
                     end else begin
                        state <= smbra_pkg::SMBRA_PTR;
                     end
                  end
                  smbra_pkg::SMBRA_PTR: begin
                     ptr        <= in_byte;
                     xfer.block <= in_byte[smbra_pkg::PTR_BLOCK_BIT];
                     state      <= in_byte[smbra_pkg::PTR_BLOCK_BIT] ? smbra_pkg::SMBRA_COUNT
                                                                     : smbra_pkg::SMBRA_DATA_W;
                  end
                  smbra_pkg::SMBRA_COUNT: begin
                     xfer.left <= clamp_count(in_byte);
                     state     <= smbra_pkg::SMBRA_DATA_W;
                  end
                  smbra_pkg::SMBRA_DATA_W: begin
                     if (xfer.block) begin
                        if (xfer.left != 6'd0) begin
                           ptr       <= {ptr[7], ptr[6:0] + 7'h01};
                           xfer.left <= xfer.left - 6'd1;
                        end else begin
                           ack_en <= 1'b0;
                        end
                     end
                  end
                  default: begin
                     state <= smbra_pkg::SMBRA_IDLE;
                  end
               endcase
            end
         end
      end
   end

   // Register storage; pointer bits 6:5 nonzero means unmapped
   always_ff @(posedge SCL) begin
      if (!link_rstn) begin
         for (int i = 0; i < smbra_pkg::NUM_REGS; i++) begin
            regs[i] <= smbra_pkg::RST_REG_VALUE;
         end
         regs[smbra_pkg::REG_BLOCK_READ_LEN] <= smbra_pkg::RST_BLOCK_READ_LEN;
      end else if (wr_en) begin
         regs[ptr[smbra_pkg::REG_IDX_W-1:0]] <= in_byte;
      end
   end

   always_ff @(posedge SCL) begin
      if (!link_rstn) begin
         link_busy <= 1'b0;
      end else begin
         link_busy <= (state != smbra_pkg::SMBRA_IDLE);
      end
   end

   // SDA changes only on falling SCL, so it is stable while SCL is high
   always_ff @(negedge SCL) begin
      if (!link_rstn) begin
         SDA_OE_N <= 1'b1;
         SDA_OUT  <= 1'b0;
      end else begin
         SDA_OUT <= 1'b0;
         if (start_pend || state == smbra_pkg::SMBRA_IDLE) begin
            SDA_OE_N <= 1'b1;
         end else if (ack_en && bitcnt == smbra_pkg::ACK_SLOT) begin
            SDA_OE_N <= 1'b0;
         end else if (state == smbra_pkg::SMBRA_READ && bitcnt != smbra_pkg::ACK_SLOT) begin
            SDA_OE_N <= tx_bit(tx, bitcnt);
         end else begin
            SDA_OE_N <= 1'b1;
         end
      end
   end

   // Checks in the link domain
   a_start_addr: assert property (@(posedge SCL) disable iff (!link_rstn)
      start_pend |=> (state == smbra_pkg::SMBRA_ADDR && bitcnt == smbra_pkg::BIT_FIRST))
      else $error("start did not begin address byte");

   a_ack_match: assert property (@(posedge SCL) disable iff (!link_rstn)
      (byte_done && state == smbra_pkg::SMBRA_ADDR && addr_hit) |=> !SDA_OE_N)
      else $error("matching address not acknowledged");

   a_nomatch_idle: assert property (@(posedge SCL) disable iff (!link_rstn)
      (byte_done && state == smbra_pkg::SMBRA_ADDR && !addr_hit)
      |=> (state == smbra_pkg::SMBRA_IDLE && SDA_OE_N))
      else $error("foreign address not ignored");

   a_ptr_load: assert property (@(posedge SCL) disable iff (!link_rstn)
      (byte_done && state == smbra_pkg::SMBRA_PTR) |=> (ptr == $past(in_byte)))
      else $error("pointer not loaded from first byte");

   a_single_store: assert property (@(posedge SCL) disable iff (!link_rstn)
      (wr_en && !xfer.block) |=> (regs[ptr[4:0]] == $past(in_byte)))
      else $error("data byte not stored");

   a_block_adv: assert property (@(posedge SCL) disable iff (!link_rstn)
      (byte_done && state == smbra_pkg::SMBRA_DATA_W && xfer.block && xfer.left != 6'd0)
      |=> (ptr[6:0] == $past(ptr[6:0]) + 7'h01))
      else $error("block pointer did not advance");

   a_block_max: assert property (@(posedge SCL) disable iff (!link_rstn)
      xfer.left <= smbra_pkg::MAX_BLOCK)
      else $error("block count above limit");

   a_stop_idle: assert property (@(posedge SCL) disable iff (!link_rstn)
      (stop_pend && !start_pend) |=> (state == smbra_pkg::SMBRA_IDLE))
      else $error("stop did not return to idle");

   a_read_count: assert property (@(posedge SCL) disable iff (!link_rstn)
      (byte_done && state == smbra_pkg::SMBRA_ADDR && addr_hit && in_byte[0] && ptr[7])
      |=> (tx == {2'b00, read_len} && state == smbra_pkg::SMBRA_READ))
      else $error("block read did not start with count");

   a_count_kept: assert property (@(posedge SCL) disable iff (!link_rstn)
      (state == smbra_pkg::SMBRA_READ && ack_en && bitcnt == smbra_pkg::ACK_SLOT)
      |=> $stable(tx))
      else $error("first read byte overwritten in address ack slot");

   a_nack_idle: assert property (@(posedge SCL) disable iff (!link_rstn)
      (state == smbra_pkg::SMBRA_READ && bitcnt == smbra_pkg::ACK_SLOT && !ack_en && SDA_IN
       && !start_pend && !stop_pend) |=> (state == smbra_pkg::SMBRA_IDLE))
      else $error("master nack did not end the read");

   a_over_refused: assert property (@(posedge SCL) disable iff (!link_rstn)
      (byte_done && state == smbra_pkg::SMBRA_DATA_W && xfer.block && xfer.left == 6'd0)
      |=> SDA_OE_N)
      else $error("byte past block count acknowledged");

   // A lost stop would otherwise leave the line held low on an idle bus
   a_idle_release: assert property (@(posedge SCL) disable iff (!link_rstn)
      (state == smbra_pkg::SMBRA_IDLE) |-> SDA_OE_N)
      else $error("data line driven while idle");

   a_read_bit: assert property (@(posedge SCL) disable iff (!link_rstn)
      (state == smbra_pkg::SMBRA_READ && bitcnt != smbra_pkg::ACK_SLOT
       && !ack_en && !start_pend) |-> (SDA_OE_N == tx_bit(tx, bitcnt)))
      else $error("read bit not driven from register");

   // Checks in the core domain
   a_addr_frozen: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      strap_taken |=> $stable(SLAVE_ADDR))
      else $error("own address changed after capture");

   a_addr_fixed: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      SLAVE_ADDR[6:2] == smbra_pkg::FIXED_ADDR_BASE[6:2])
      else $error("own address outside the fixed range");

   c_write_byte: cover property (@(posedge SCL) disable iff (!link_rstn)
      wr_en && !xfer.block);
   c_block_write: cover property (@(posedge SCL) disable iff (!link_rstn)
      wr_en && xfer.block);
   c_repeat_read: cover property (@(posedge SCL) disable iff (!link_rstn)
      (state == smbra_pkg::SMBRA_DATA_W) ##1 start_pend ##[1:20] (state == smbra_pkg::SMBRA_READ));
   c_block_read: cover property (@(posedge SCL) disable iff (!link_rstn)
      state == smbra_pkg::SMBRA_READ && xfer.block && bitcnt == smbra_pkg::ACK_SLOT && !SDA_IN);
   c_foreign_addr: cover property (@(posedge SCL) disable iff (!link_rstn)
      byte_done && state == smbra_pkg::SMBRA_ADDR && !addr_hit);

endmodule
`default_nettype wire

// ==== verif/smbra_host.sv ====
`timescale 1ns/10ps
`default_nettype none
// Bus master model; the clock stands high between frames, each bit takes 6 ns
module smbra_host (
   output logic      scl,
   output logic      sda_low,
   input  wire logic sda
);
   initial begin
      scl     = 1'b1;
      sda_low = 1'b0;
   end

   // Clock pulse with the data line released, no start made
   task automatic idle_pulse();
      scl = 1'b0;
      #3 scl = 1'b1;
      #3;
   endtask

   // Works from idle and as a repeated start after an ack slot
   task automatic start();
      #1 sda_low = 1'b0;
      #2 scl = 1'b1;
      #2 sda_low = 1'b1;
      #2 scl = 1'b0;
   endtask

   // Line taken low in the clock low period, then raised with the clock high
   task automatic stop();
      #1 sda_low = 1'b1;
      #2 scl = 1'b1;
      #2 sda_low = 1'b0;
      #2;
   endtask

   // Data changes a nanosecond after the fall so no edge is read as start or stop
   task automatic put_bit(input logic b);
      #1 sda_low = ~b;
      #2 scl = 1'b1;
      #3 scl = 1'b0;
   endtask

   task automatic get_bit(output logic b);
      #1 sda_low = 1'b0;
      #2 scl = 1'b1;
      b = sda;
      #3 scl = 1'b0;
   endtask

   // Ack returns 1 when the device pulled the line low
   task automatic send_byte(input logic [7:0] d, output logic ack);
      logic b;
      for (int i = 7; i >= 0; i--) put_bit(d[i]);
      get_bit(b);
      ack = ~b;
   endtask

   // Master acks with 0, ends a read with a high nack
   task automatic recv_byte(input logic last, output logic [7:0] d);
      for (int i = 7; i >= 0; i--) get_bit(d[i]);
      put_bit(last);
   endtask
endmodule
`default_nettype wire

// ==== verif/smbus_register_access_slave_test.sv ====
`timescale 1ns/10ps
`default_nettype none
module smbus_register_access_slave_test;
   logic       core_clk;
   logic       rstn;
   logic [1:0] strap;
   logic       sda_out;
   logic       sda_oe_n;
   logic [6:0] slave_addr;
   logic       busy;
   logic       scl;
   logic       sda_low;
   wire logic  sda;
   int         fail_count;
   int         checks_done;
   int         seed;
   logic [6:0] own;
   logic [7:0] mem [0:31];
   logic [7:0] p;
   logic [7:0] q;
   logic [7:0] v;
   logic [7:0] n;

   // Open-drain wire with pull-up
   assign sda = sda_low ? 1'b0 : (sda_oe_n ? 1'b1 : sda_out);

   smbra_slave i_dut (
      .CORE_CLK          (core_clk),
      .RSTN              (rstn),
      .SCL               (scl),
      .SDA_IN            (sda),
      .SDA_OUT           (sda_out),
      .SDA_OE_N          (sda_oe_n),
      .ADDRESS_STRAP_PIN (strap),
      .SLAVE_ADDR        (slave_addr),
      .BUSY              (busy)
   );

   smbra_host i_host (
      .scl     (scl),
      .sda_low (sda_low),
      .sda     (sda)
   );

   always #20 core_clk = ~core_clk;

   function automatic logic [6:0] exp_addr(input logic [1:0] s);
      return smbra_pkg::FIXED_ADDR_BASE | {5'h00, s};
   endfunction

   function automatic logic [7:0] exp_count(input logic [7:0] len);
      return (len > 8'h20) ? 8'h20 : len;
   endfunction

   task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic check_ack(input logic got, input logic exp);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic print_verdict();
      $display("Totals: %0d checks, %0d mismatches", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic open_xfer(input logic rd, input logic [6:0] a, input logic exp_ack);
      logic k;
      i_host.start();
      i_host.send_byte({a, rd}, k);
      check_ack(k, exp_ack);
   endtask

   task automatic put(input logic [7:0] d, input logic exp_ack);
      logic k;
      i_host.send_byte(d, k);
      check_ack(k, exp_ack);
   endtask

   task automatic get(input logic last, input logic [7:0] exp);
      logic [7:0] d;
      i_host.recv_byte(last, d);
      check_byte(d, exp);
   endtask

   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      open_xfer(1'b0, own, 1'b1);
      put(a, 1'b1);
      put(d, 1'b1);
      i_host.stop();
      mem[a[4:0]] = d;
   endtask

   // Pointer write, repeated start, single read
   task automatic read_at(input logic [7:0] a);
      open_xfer(1'b0, own, 1'b1);
      put(a, 1'b1);
      open_xfer(1'b1, own, 1'b1);
      get(1'b1, mem[a[4:0]]);
      i_host.stop();
   endtask

   initial begin
      core_clk = 1'b0;
      rstn = 1'b0;
      strap = 2'h0;
      fail_count = 0;
      checks_done = 0;
      seed = 47198;
      for (int i = 0; i < 32; i++) mem[i] = smbra_pkg::RST_REG_VALUE;
      mem[0] = smbra_pkg::RST_BLOCK_READ_LEN;
      @(posedge core_clk);
      strap <= 2'($random(seed));
      // Reset needs link edges and one start/stop toggle to settle the detectors
      fork
         repeat (16) @(posedge core_clk);
         begin
            repeat (6) i_host.idle_pulse();
            i_host.start();
            i_host.stop();
            repeat (4) i_host.idle_pulse();
         end
      join
      rstn <= 1'b1;
      repeat (4) i_host.idle_pulse();
      repeat (3) @(posedge core_clk);
      own = exp_addr(strap);
      check_byte({1'b0, slave_addr}, {1'b0, own});
      $display("Test reset done");
      // Foreign address: no ack and the line stays released
      open_xfer(1'b0, own ^ 7'h08, 1'b0);
      put(8'h01, 1'b0);
      i_host.stop();
      $display("Test foreign address done");
      for (int t = 0; t < 4; t++) begin
         p = {3'h0, 5'($random(seed))} | 8'h01;
         q = {3'h0, 5'($random(seed))} | 8'h01;
         write_reg(p, 8'($random(seed)));
         open_xfer(1'b0, own, 1'b1);
         put(q, 1'b1);
         i_host.stop();
         open_xfer(1'b1, own, 1'b1);
         get(1'b1, mem[q[4:0]]);
         i_host.stop();
         read_at(p);
      end
      $display("Test single transfers done");
      // Count above the limit is clamped, 33rd byte refused
      open_xfer(1'b0, own, 1'b1);
      put(8'h80, 1'b1);
      put(8'h28, 1'b1);
      for (int i = 0; i < 33; i++) begin
         v = 8'($random(seed));
         put(v, 1'(i < 32));
         if (i < 32) mem[i] = v;
      end
      i_host.stop();
      read_at(8'h1f);
      read_at(8'h00);
      $display("Test block write clamp done");
      n = 8'h03 + 8'($random(seed) & 3);
      open_xfer(1'b0, own, 1'b1);
      put(8'h88, 1'b1);
      put(n, 1'b1);
      for (int i = 0; i < n; i++) begin
         v = 8'($random(seed));
         put(v, 1'b1);
         mem[8 + i] = v;
      end
      put(8'h5a, 1'b0);
      i_host.stop();
      write_reg(8'h00, n);
      open_xfer(1'b0, own, 1'b1);
      put(8'h88, 1'b1);
      open_xfer(1'b1, own, 1'b1);
      repeat (3) @(posedge core_clk);
      check_ack(busy, 1'b1);
      get(1'b0, exp_count(n));
      for (int i = 0; i < n; i++) get(1'b0, mem[8 + i]);
      get(1'b1, smbra_pkg::PAST_BLOCK_READ);
      i_host.stop();
      repeat (2) i_host.idle_pulse();
      repeat (5) @(posedge core_clk);
      check_ack(busy, 1'b0);
      check_ack(sda_out, 1'b0);
      $display("Test block read done");
      print_verdict();
   end

   // Watchdog against a hang
   initial begin
      repeat (100000) @(posedge core_clk);
      fail_count++;
      print_verdict();
   end
endmodule
`default_nettype wire
